// *** uart_irq_consts.svh ***
/*
 * Register addresses, field positions and reset values of the UART interrupt
 * and fractional divider block.
 * Assumes a 32-bit byte address on the register port, one register a word.
 */
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

// ==========================================================================
// register addresses
`define UART_ADDR_IRQ_EN 32'hffff0704
`define UART_ADDR_IRQ_ID 32'hffff0708
`define UART_ADDR_LINE_STAT 32'hffff0714
`define UART_ADDR_FRAC_DIV 32'hffff072c
`define UART_ADDR_TX_DATA 32'hffff0740
`define UART_ADDR_RX_DATA 32'hffff0744
`define UART_ADDR_MODEM_STAT 32'hffff0748

// ==========================================================================
// reset values
`define UART_IRQ_EN_RST 4'h0
`define UART_IRQ_ID_IDLE 8'h01
`define UART_LINE_STAT_RST 8'h60
`define UART_FRAC_DIV_RST 16'h0000

// ==========================================================================
// field positions
`define UART_IE_MODEM 3
`define UART_IE_LINE 2
`define UART_IE_TX 1
`define UART_IE_RX 0
`define UART_FD_EN 15
`define UART_FD_MULT_HI 12
`define UART_FD_MULT_LO 11
`define UART_FD_NUMER_HI 10
`define UART_FRAC_MULT_ZERO 3'h4

`endif

// *** uart_irq_pkg.sv ***
/*
 * Types of the UART interrupt and fractional divider block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package uart_irq_pkg;
    // codes as they appear in bits 2:1 of the identification register
    typedef enum logic [1:0] {
        SRC_MODEM = 2'h0,
        SRC_TX = 2'h1,
        SRC_RX = 2'h2,
        SRC_LINE = 2'h3
    } irq_src_t;
endpackage

`default_nettype wire

// *** uart_irq_frac.sv ***
/*
 * UART interrupt enables, prioritised interrupt identification, line and
 * modem status flags, transmit/receive data holding and fractional divider
 * control.
 * Assumes the receive/transmit shifters and modem pin logic run on core_clk
 * and hand over events as one-cycle pulses; software uses a plain register
 * port with read data one cycle after the read strobe.
 */
// How it works
// R01 - modem status enable plus any modem delta bit 3..1 raises the interrupt
// R02 - line status enable plus framing, parity or overrun flag raises the interrupt
// R03 - transmit empty enable raises the interrupt when the holding register empties, until a tx write or an ident read that reports transmit
// R04 - receive full enable raises the interrupt when a received byte waits
// R05 - identification register reads 0x01 when idle and after reset; bit 0 low means pending
// R06 - bits 2:1 report highest source: line 11, receive 10, transmit 01, modem 00
// R07 - line read, data read, tx write or ident read, modem read clear their source
// R08 - divider bit 15 selects fractional generator, clear selects the standard divisor
// R09 - multiplier comes from bits 12:11, zero means four
// R10 - numerator comes from divider bits 10:0
// R11 - framing, parity and overrun set line bits 3, 2, 1, cleared by a line status read
// R12 - holding empty bit 5 sets when the shifter takes a byte, clears on tx write
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.svh"

module uart_irq_frac (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [31:0] rdData,
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    input wire logic rxFrameErr,
    input wire logic rxParityErr,
    input wire logic rxBreak,
    input wire logic txTaken,
    input wire logic txShiftIdle,
    input wire logic [3:0] modemEvent,
    input wire logic [3:0] modemLines,
    output logic [7:0] txData,
    output logic txLoad,
    output logic uartIrq,
    output uart_irq_pkg::irq_src_t irqSource,
    output logic fracGenEn,
    output logic [2:0] fracMult,
    output logic [10:0] fracNumer
);
    import uart_irq_pkg::*;

    // ======================================================================
    // helpers
    // a flag that hardware sets and a reader clears: the set wins
    function automatic logic setWins(input logic cur, input logic set, input logic clr);
        setWins = set | (cur & ~clr);
    endfunction

    // ======================================================================
    // state
    logic [3:0] irqEn_r;
    logic [15:0] fracDiv_r;
    logic dataReady_r;
    logic overrun_r;
    logic parity_r;
    logic framing_r;
    logic break_r;
    logic txHoldEmpty_r;
    logic txAllEmpty_r;
    logic txIrqFlag_r;
    logic [3:0] modemDelta_r;
    logic [3:0] modemLines_r;
    logic [7:0] rxData_r;
    logic [7:0] txData_r;
    logic txLoad_r;
    logic [31:0] rdData_r;
    logic uartIrq_r;
    irq_src_t irqSource_r;
    logic fracGenEn_r;
    logic [2:0] fracMult_r;
    logic [10:0] fracNumer_r;

    // ======================================================================
    // address decode
    logic wrIrqEn;
    logic wrFracDiv;
    logic wrTx;
    logic rdIrqId;
    logic rdLine;
    logic rdRx;
    logic rdModem;

    assign wrIrqEn = wrEn && (addr == `UART_ADDR_IRQ_EN);
    assign wrFracDiv = wrEn && (addr == `UART_ADDR_FRAC_DIV);
    assign wrTx = wrEn && (addr == `UART_ADDR_TX_DATA);
    assign rdIrqId = rdEn && (addr == `UART_ADDR_IRQ_ID);
    assign rdLine = rdEn && (addr == `UART_ADDR_LINE_STAT);
    assign rdRx = rdEn && (addr == `UART_ADDR_RX_DATA);
    assign rdModem = rdEn && (addr == `UART_ADDR_MODEM_STAT);

    // ======================================================================
    // interrupt sources and priority
    logic linePend;
    logic rxPend;
    logic txPend;
    logic modemPend;
    logic anyPend;
    irq_src_t topSrc;
    logic [7:0] irqIdValue;
    logic [7:0] lineStatValue;

    assign modemPend = irqEn_r[`UART_IE_MODEM] && (|modemDelta_r[3:1]); // R01
    assign linePend = irqEn_r[`UART_IE_LINE] && (framing_r || parity_r || overrun_r); // R02
    assign txPend = irqEn_r[`UART_IE_TX] && txIrqFlag_r; // R03
    assign rxPend = irqEn_r[`UART_IE_RX] && dataReady_r; // R04
    assign anyPend = linePend || rxPend || txPend || modemPend;

    always_comb begin
        if (linePend) begin // R06
            topSrc = SRC_LINE;
        end else if (rxPend) begin
            topSrc = SRC_RX;
        end else if (txPend) begin
            topSrc = SRC_TX;
        end else begin
            topSrc = SRC_MODEM;
        end
    end

    // bit 0 is low while something is pending
    assign irqIdValue = anyPend ? {5'h00, topSrc, 1'b0} : `UART_IRQ_ID_IDLE; // R05 R06

    assign lineStatValue = {1'b0, txAllEmpty_r, txHoldEmpty_r, break_r,
                            framing_r, parity_r, overrun_r, dataReady_r};

    // ======================================================================
    // software registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqEn_r <= `UART_IRQ_EN_RST;
        end else if (wrIrqEn) begin
            irqEn_r <= wrData[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fracDiv_r <= `UART_FRAC_DIV_RST;
        end else if (wrFracDiv) begin
            // reserved bits 14:13 are kept at zero
            fracDiv_r <= {wrData[15], 2'h0, wrData[12:0]};
        end
    end

    // ======================================================================
    // baud generator control, handed to the rate logic
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fracGenEn_r <= 1'b0;
            fracMult_r <= `UART_FRAC_MULT_ZERO;
            fracNumer_r <= 11'h000;
        end else begin
            fracGenEn_r <= fracDiv_r[`UART_FD_EN]; // R08
            // a zero field stands for four, so the rate logic never sees zero
            if (fracDiv_r[`UART_FD_MULT_HI:`UART_FD_MULT_LO] == 2'h0) begin // R09
                fracMult_r <= `UART_FRAC_MULT_ZERO;
            end else begin
                fracMult_r <= {1'b0, fracDiv_r[`UART_FD_MULT_HI:`UART_FD_MULT_LO]};
            end
            fracNumer_r <= fracDiv_r[`UART_FD_NUMER_HI:0]; // R10
        end
    end

    // ======================================================================
    // receive side flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataReady_r <= 1'b0;
            rxData_r <= 8'h00;
        end else begin
            dataReady_r <= setWins(dataReady_r, rxByteValid, rdRx); // R07
            if (rxByteValid) begin
                rxData_r <= rxByte;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_r <= 1'b0;
            parity_r <= 1'b0;
            framing_r <= 1'b0;
            break_r <= 1'b0;
        end else begin
            // overrun: a new byte while the last one was never read
            overrun_r <= setWins(overrun_r, rxByteValid && dataReady_r && !rdRx, rdLine); // R11 R07
            parity_r <= setWins(parity_r, rxByteValid && rxParityErr, rdLine); // R11
            framing_r <= setWins(framing_r, rxByteValid && rxFrameErr, rdLine); // R11
            break_r <= setWins(break_r, rxBreak, rdLine);
        end
    end

    // ======================================================================
    // transmit side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txHoldEmpty_r <= 1'b1;
            txAllEmpty_r <= 1'b1;
            txData_r <= 8'h00;
            txLoad_r <= 1'b0;
        end else begin
            txHoldEmpty_r <= setWins(txHoldEmpty_r, txTaken, wrTx); // R12
            txAllEmpty_r <= txShiftIdle && txHoldEmpty_r && !wrTx;
            txLoad_r <= wrTx;
            if (wrTx) begin
                txData_r <= wrData[7:0];
            end
        end
    end

    // the empty interrupt is an event, so reading the ident register can drop
    // it while the holding register is still empty
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txIrqFlag_r <= 1'b1;
        end else begin
            txIrqFlag_r <= setWins(txIrqFlag_r,
                txTaken || (wrIrqEn && wrData[`UART_IE_TX] && !irqEn_r[`UART_IE_TX] && txHoldEmpty_r),
                wrTx || (rdIrqId && anyPend && topSrc == SRC_TX)); // R03 R07
        end
    end

    // ======================================================================
    // modem status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modemDelta_r <= 4'h0;
            modemLines_r <= 4'h0;
        end else begin
            modemLines_r <= modemLines;
            for (int i = 0; i < 4; i++) begin
                modemDelta_r[i] <= setWins(modemDelta_r[i], modemEvent[i], rdModem); // R07
            end
        end
    end

    // ======================================================================
    // read port: data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= 32'h0000_0000;
        end else if (!rdEn) begin
            rdData_r <= 32'h0000_0000;
        end else begin
            unique case (addr)
                `UART_ADDR_IRQ_EN: rdData_r <= {28'h0000000, irqEn_r};
                `UART_ADDR_IRQ_ID: rdData_r <= {24'h000000, irqIdValue}; // R05
                `UART_ADDR_LINE_STAT: rdData_r <= {24'h000000, lineStatValue};
                `UART_ADDR_FRAC_DIV: rdData_r <= {16'h0000, fracDiv_r};
                `UART_ADDR_RX_DATA: rdData_r <= {24'h000000, rxData_r};
                `UART_ADDR_MODEM_STAT: rdData_r <= {24'h000000, modemLines_r, modemDelta_r};
                default: rdData_r <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // interrupt output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uartIrq_r <= 1'b0;
            irqSource_r <= SRC_MODEM;
        end else begin
            uartIrq_r <= anyPend; // R01 R02 R03 R04
            irqSource_r <= topSrc;
        end
    end

    assign rdData = rdData_r;
    assign txData = txData_r;
    assign txLoad = txLoad_r;
    assign uartIrq = uartIrq_r;
    assign irqSource = irqSource_r;
    assign fracGenEn = fracGenEn_r;
    assign fracMult = fracMult_r;
    assign fracNumer = fracNumer_r;

    // ======================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_modem_irq_raise: assert property (modemPend |=> uartIrq) // R01
        else $error("modem status did not raise the interrupt");
    a_line_irq_raise: assert property ((irqEn_r[2] && (framing_r || parity_r || overrun_r)) |=> uartIrq) // R02
        else $error("line error did not raise the interrupt");
    a_tx_irq_raise: assert property ((irqEn_r[1] && txIrqFlag_r) |=> uartIrq) // R03
        else $error("transmit empty did not raise the interrupt");
    a_rx_irq_raise: assert property ((irqEn_r[0] && dataReady_r) |=> uartIrq) // R04
        else $error("receive full did not raise the interrupt");
    a_ident_idle_read: assert property ((rdIrqId && !anyPend) |=> (rdData == 32'h0000_0001)) // R05
        else $error("idle identification read is not 0x01");
    a_ident_line_first: assert property ((rdIrqId && linePend) |=> (rdData[2:0] == 3'h6)) // R06
        else $error("line status not reported first");
    a_ident_rx_second: assert property ((rdIrqId && rxPend && !linePend) |=> (rdData[2:0] == 3'h4)) // R06
        else $error("receive full not reported second");
    a_line_read_clears: assert property ((rdLine && !rxByteValid) |=> !(framing_r || parity_r || overrun_r)) // R07
        else $error("line status read did not clear errors");
    a_frac_enable_sel: assert property ((wrFracDiv && wrData[15]) |=> ##1 fracGenEn) // R08
        else $error("fractional generator not selected");
    a_frac_mult_zero: assert property ((wrFracDiv && wrData[12:11] == 2'h0) |=> ##1 (fracMult == 3'h4)) // R09
        else $error("zero multiplier field is not four");
    a_frac_numer_take: assert property (wrFracDiv |=> ##1 (fracNumer == $past(wrData[10:0], 2))) // R10
        else $error("numerator not taken from bits 10:0");
    a_framing_sets: assert property ((rxByteValid && rxFrameErr) |=> framing_r) // R11
        else $error("framing error flag not set");
    a_tx_write_clears: assert property ((wrTx && !txTaken) |=> (!txHoldEmpty_r && txLoad)) // R12
        else $error("transmit write did not clear holding empty");
    a_parity_sets: assert property ((rxByteValid && rxParityErr) |=> parity_r) // R11
        else $error("parity error flag not set");
    a_overrun_sets: assert property ((rxByteValid && dataReady_r && !rdRx) |=> overrun_r) // R11
        else $error("overrun flag not set");
    a_irq_drops_idle: assert property (!anyPend |=> !uartIrq) // R05
        else $error("interrupt stands with nothing pending");
    // lower priorities only show when every higher source is quiet
    a_ident_tx_third: assert property ( // R06
        (rdIrqId && txPend && !(linePend || rxPend)) |=> (rdData[2:0] == 3'h2))
        else $error("transmit empty not reported third");
    a_ident_modem_last: assert property ( // R06
        (rdIrqId && modemPend && !(linePend || rxPend || txPend)) |=> (rdData[2:0] == 3'h0))
        else $error("modem status not reported last");
    a_frac_gen_off: assert property ((wrFracDiv && !wrData[15]) |=> ##1 !fracGenEn) // R08
        else $error("standard divisor not selected");
    a_frac_mult_take: assert property ( // R09
        (wrFracDiv && wrData[12:11] != 2'h0) |=> ##1 (fracMult == {1'b0, $past(wrData[12:11], 2)}))
        else $error("multiplier not taken from bits 12:11");
    // clears only hold when no set event lands in the same cycle
    a_rx_read_clears: assert property ((rdRx && !rxByteValid) |=> !dataReady_r) // R07
        else $error("receive data read did not clear data ready");
    a_modem_read_clears: assert property ((rdModem && modemEvent == 4'h0) |=> (modemDelta_r == 4'h0)) // R07
        else $error("modem status read did not clear deltas");
    a_tx_write_drops: assert property ((wrTx && !txTaken) |=> !txIrqFlag_r) // R07
        else $error("transmit write did not drop the empty interrupt");

endmodule

`default_nettype wire

// *** uart_line_model.sv ***
/*
 * Far-side model: receive and transmit shifters and modem pins of the line.
 * Assumes the bench calls its tasks and sets txDelay on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module uart_line_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic txLoad,
    input wire logic [7:0] txDelay,
    output var logic rxByteValid,
    output var logic [7:0] rxByte,
    output var logic rxFrameErr,
    output var logic rxParityErr,
    output var logic rxBreak,
    output var logic txTaken,
    output var logic txShiftIdle,
    output var logic [3:0] modemEvent,
    output var logic [3:0] modemLines
);
    logic [7:0] cnt;

    initial begin
        rxByteValid = 1'b0;
        rxByte = 8'h00;
        rxFrameErr = 1'b0;
        rxParityErr = 1'b0;
        rxBreak = 1'b0;
        modemEvent = 4'h0;
        modemLines = 4'h9;
    end

    // =====================================================================
    // shifter: takes the holding byte txDelay cycles after a load
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            txTaken <= 1'b0;
            txShiftIdle <= 1'b1;
        end else begin
            txTaken <= (cnt == 8'h01);
            txShiftIdle <= (cnt == 8'h00) && !txLoad;
            if (txLoad) begin
                cnt <= txDelay;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    // =====================================================================
    // receive: outside the pulse the byte lines carry the inverse, not stale data
    task sendByte(input logic [7:0] b, input logic fe, input logic pe);
        @(posedge core_clk);
        rxByteValid <= 1'b1;
        rxByte <= b;
        rxFrameErr <= fe;
        rxParityErr <= pe;
        @(posedge core_clk);
        rxByteValid <= 1'b0;
        rxByte <= ~b;
        rxFrameErr <= 1'b0;
        rxParityErr <= 1'b0;
    endtask

    task lineBreak;
        @(posedge core_clk);
        rxBreak <= 1'b1;
        @(posedge core_clk);
        rxBreak <= 1'b0;
    endtask

    task modem(input logic [3:0] ev);
        @(posedge core_clk);
        modemEvent <= ev;
        @(posedge core_clk);
        modemEvent <= 4'h0;
    endtask
endmodule

`default_nettype wire

// *** tb_uart_irq_frac.sv ***
/*
 * Self-checking bench of the UART interrupt and fractional divider block.
 * Assumes the line model sits on the shifter side; 20 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.svh"

module tb_uart_irq_frac;
    import uart_irq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wrData = 32'h0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [7:0] txDelay = 8'h14;
    logic [31:0] rdData;
    logic rxByteValid, rxFrameErr, rxParityErr, rxBreak, txTaken, txShiftIdle;
    logic [7:0] rxByte, txData;
    logic [3:0] modemEvent, modemLines;
    logic txLoad, uartIrq, fracGenEn;
    irq_src_t irqSource;
    logic [2:0] fracMult;
    logic [10:0] fracNumer;
    logic [10:0] n;
    int failures = 0;
    int numChecks = 0;
    int cycleCount = 0;

    always #25 core_clk = ~core_clk;

    uart_irq_frac uart_irq_frac_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rxByteValid(rxByteValid), .rxByte(rxByte),
        .rxFrameErr(rxFrameErr), .rxParityErr(rxParityErr), .rxBreak(rxBreak), .txTaken(txTaken),
        .txShiftIdle(txShiftIdle), .modemEvent(modemEvent), .modemLines(modemLines), .txData(txData),
        .txLoad(txLoad), .uartIrq(uartIrq), .irqSource(irqSource), .fracGenEn(fracGenEn),
        .fracMult(fracMult), .fracNumer(fracNumer));

    uart_line_model uart_line_model_inst (.core_clk(core_clk), .rst_n(rst_n), .txLoad(txLoad),
        .txDelay(txDelay), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameErr(rxFrameErr),
        .rxParityErr(rxParityErr), .rxBreak(rxBreak), .txTaken(txTaken), .txShiftIdle(txShiftIdle),
        .modemEvent(modemEvent), .modemLines(modemLines));

    // =====================================================================
    // bus and compare
    task chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks = numChecks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge core_clk);
        wrEn <= 1'b0;
    endtask

    task rdc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge core_clk);
        rdEn <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask

    task settle(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    // =====================================================================
    // scenarios
    task t_reset;
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
        rdc(`UART_ADDR_IRQ_EN, 32'h00);
        rdc(`UART_ADDR_LINE_STAT, 32'h60);
        rdc(`UART_ADDR_FRAC_DIV, 32'h0000);
        rdc(32'hffff0700, 32'h0);
        chk(fracMult, 32'h4);
        chk(uartIrq, 32'h0);
    endtask

    task t_tx;
        wr(`UART_ADDR_IRQ_EN, 32'h2);
        settle(3);
        chk(uartIrq, 32'h1);
        chk(irqSource, SRC_TX);
        rdc(`UART_ADDR_IRQ_ID, 32'h02);
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
        wr(`UART_ADDR_TX_DATA, 32'h5a);
        #1;
        chk(txData, 32'h5a);
        chk(txLoad, 32'h1);
        rdc(`UART_ADDR_LINE_STAT, 32'h00);
        settle(25);
        chk(uartIrq, 32'h1);
        rdc(`UART_ADDR_LINE_STAT, 32'h60);
        txDelay <= 8'h01;
        wr(`UART_ADDR_TX_DATA, 32'ha3);
        settle(4);
        chk(uartIrq, 32'h1);
        wr(`UART_ADDR_TX_DATA, 32'h00);
        settle(1);
        chk(uartIrq, 32'h0);
        settle(4);
        rdc(`UART_ADDR_IRQ_ID, 32'h02);
    endtask

    task t_rx_line;
        wr(`UART_ADDR_IRQ_EN, 32'h1);
        uart_line_model_inst.sendByte(8'ha5, 1'b0, 1'b0);
        settle(2);
        chk(uartIrq, 32'h1);
        rdc(`UART_ADDR_IRQ_ID, 32'h04);
        rdc(`UART_ADDR_RX_DATA, 32'ha5);
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
        wr(`UART_ADDR_IRQ_EN, 32'h5);
        uart_line_model_inst.sendByte(8'h3c, 1'b1, 1'b1);
        settle(2);
        rdc(`UART_ADDR_IRQ_ID, 32'h06);
        rdc(`UART_ADDR_LINE_STAT, 32'h6d);
        rdc(`UART_ADDR_LINE_STAT, 32'h61);
        rdc(`UART_ADDR_IRQ_ID, 32'h04);
        uart_line_model_inst.sendByte(8'h11, 1'b0, 1'b0);
        settle(2);
        rdc(`UART_ADDR_IRQ_ID, 32'h06);
        rdc(`UART_ADDR_LINE_STAT, 32'h63);
        rdc(`UART_ADDR_RX_DATA, 32'h11);
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
        uart_line_model_inst.lineBreak;
        settle(2);
        rdc(`UART_ADDR_LINE_STAT, 32'h70);
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
    endtask

    task t_modem;
        wr(`UART_ADDR_IRQ_EN, 32'h8);
        uart_line_model_inst.modem(4'h1);
        settle(3);
        chk(uartIrq, 32'h0);
        uart_line_model_inst.modem(4'h4);
        settle(3);
        chk(uartIrq, 32'h1);
        rdc(`UART_ADDR_IRQ_ID, 32'h00);
        rdc(`UART_ADDR_MODEM_STAT, 32'h95);
        rdc(`UART_ADDR_IRQ_ID, 32'h01);
    endtask

    task t_div;
        for (int m = 0; m < 4; m++) begin
            n = 11'h7ff ^ (11'(m) * 11'h2aa);
            wr(`UART_ADDR_FRAC_DIV, 32'he000 | (m << 11) | n);
            settle(2);
            chk(fracGenEn, 32'h1);
            chk(fracMult, (m == 0) ? 32'h4 : m);
            chk(fracNumer, n);
            rdc(`UART_ADDR_FRAC_DIV, 32'h8000 | (m << 11) | n);
        end
        wr(`UART_ADDR_FRAC_DIV, 32'h0);
        settle(2);
        chk(fracGenEn, 32'h0);
        wr(`UART_ADDR_IRQ_EN, 32'hff);
        rdc(`UART_ADDR_IRQ_EN, 32'h0f);
    endtask

    // =====================================================================
    // run control
    task conclude;
        if (failures == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000) begin
            failures = failures + 1;
            conclude;
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_tx;
        t_rx_line;
        t_modem;
        t_div;
        conclude;
    end
endmodule

`default_nettype wire
